// ---- hdl/intc_defs.svh ----
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// Register addresses in the special-function area
`define ADDR_ENABLE_LOW 8'h3a
`define ADDR_ENABLE_HIGH 8'h3b
`define ADDR_LATCH_LOW 8'h3c
`define ADDR_LATCH_HIGH 8'h3d

// Latch positions
`define IL_TRAP 2
`define IL_WDOG 3
`define IL_FIRST_MASK 4
`define IL_PIN0 4
`define IL_SHARED 11
`define IL_LAST 15
`define IL_PIN1 5
`define IL_TBASE 6
`define IL_TMR1 7
`define IL_RX 8
`define IL_TX 9
`define IL_TMR3 10
`define IL_ADC 12
`define IL_SEI 13
`define IL_PIN4 14
`define IL_PIN5 15
`define IMF_BIT 0

// Vector addresses
`define VEC_RESET 16'hfffe
`define VEC_SOFT 16'hfffc
`define VEC_TRAP 16'hfffa
`define VEC_WDOG 16'hfff8
`define VEC_IL4 16'hfff6
`define VEC_STEP 16'h0002

// Reset values and timing
`define LATCH_RESET 16'h0000
`define ENABLE_RESET 12'h000
`define ACCEPT_MCYCLES 8
`define MCYCLE_CLOCKS 4
`define STACK_DEPTH 8

`endif

// ---- hdl/intc_pkg.sv ----
package intc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sfr_req_t;

  typedef struct packed {
    logic address_trap_irq;
    logic watchdog_irq;
    logic ext_pin_zero_irq;
    logic ext_pin_one_irq;
    logic time_base_irq;
    logic timer_one_irq;
    logic serial_receive_irq;
    logic serial_transmit_irq;
    logic timer_three_irq;
    logic timer_four_irq;
    logic ext_pin_three_irq;
    logic converter_done_irq;
    logic serial_expansion_irq;
    logic ext_pin_four_irq;
    logic ext_pin_five_irq;
    logic software_irq;
    logic undefined_opcode_irq;
  } src_req_t;

  typedef enum logic {st_idle, st_seq} ctl_state_t;

endpackage

// ---- hdl/prioritized_interrupt_latch_controller.sv ----
`timescale 1ns/1ps
`include "intc_defs.svh"

// Operation
// - Seventeen sources besides reset; four internal ones are non-maskable.
// - A hardware request sets its latch, which asks the CPU if enabled.
// - Accepting an interrupt clears that source's latch at once.
// - Reset clears every request latch.
// - Latches sit at 0x3c/0x3d; writing zero clears only that bit.
// - Writing one to a latch bit does nothing.
// - Reading the latch registers returns the current pending bits.
// - Maskable needs master and own enable; pin 0 also its pin enable.
// - Fixed priority: reset, non-maskable, then latches 4 to 15 ascending.
// - Among the non-maskable sources, software ranks over trap and trap over watchdog.
// - Vectors fffe, fffc, fffa, fff8, then fff6 down by two to ffe0.
// - Software and undefined-opcode have no latch; trap 2, watchdog 3.
// - Level 12 uses latch 11: timer four when select 0, pin three when 1.
// - Acceptance saves master enable then clears it; return restores it.
// - Acceptance takes 8 machine cycles after the current instruction.
// - The unselected source of the shared level is never latched.
module prioritized_interrupt_latch_controller #(
  parameter int MCYCLE_CLOCKS = `MCYCLE_CLOCKS,
  parameter int ACCEPT_MCYCLES = `ACCEPT_MCYCLES,
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  input wire logic mclk, // System clock
  input wire logic reset, // Synchronous reset
  input wire intc_pkg::sfr_req_t sfr, // Register access from the core
  output logic [7:0] rdata_q, // Read data, one cycle after rd
  input wire intc_pkg::src_req_t src, // Request pulses from sources
  input wire logic level12_source_select, // 0 timer four, 1 pin three
  input wire logic ext_pin0_enable, // Pin 0 enable
  input wire logic trap_output_select, // 1 trap gives reset
  input wire logic watchdog_output_select, // 1 watchdog gives reset
  input wire logic instr_done, // Current instruction completes
  input wire logic return_from_maskable, // Return instruction pulse
  output logic irq_request_q, // Latched request ready to accept
  output logic [15:0] vector_q, // Vector of best request
  output logic accepting_q, // Acceptance sequence running
  output logic accept_done_q, // Pulse in the cycle after acceptance ends
  output logic [15:0] accepted_vector_q, // Vector being serviced
  output logic master_enable_flag_q, // Master enable
  output logic malfunction_reset_q // Trap or watchdog reset request
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] latch_q, latch_d;
  logic [15:4] source_enable_flag_q, source_enable_flag_d;
  logic master_enable_flag_d;
  logic [STACK_DEPTH-1:0] saved_enable_q, saved_enable_d;
  logic [15:0] set_vec, wr_clr, acc_clr, eligible;
  logic [15:0] win_vec;
  logic [15:0] win_clr;
  logic win_valid, soft_req, accept;
  logic [7:0] rdata_d;
  logic irq_request_d;
  logic malfunction_reset_d;

  // Request sources onto latch positions
  always_comb begin
    set_vec = 16'h0000;
    set_vec[`IL_TRAP] = src.address_trap_irq & ~trap_output_select;
    set_vec[`IL_WDOG] = src.watchdog_irq & ~watchdog_output_select;
    set_vec[`IL_PIN0] = src.ext_pin_zero_irq;
    set_vec[`IL_PIN1] = src.ext_pin_one_irq;
    set_vec[`IL_TBASE] = src.time_base_irq;
    set_vec[`IL_TMR1] = src.timer_one_irq;
    set_vec[`IL_RX] = src.serial_receive_irq;
    set_vec[`IL_TX] = src.serial_transmit_irq;
    set_vec[`IL_TMR3] = src.timer_three_irq;
    set_vec[`IL_SHARED] = level12_source_select ? src.ext_pin_three_irq
                                                : src.timer_four_irq;
    set_vec[`IL_ADC] = src.converter_done_irq;
    set_vec[`IL_SEI] = src.serial_expansion_irq;
    set_vec[`IL_PIN4] = src.ext_pin_four_irq;
    set_vec[`IL_PIN5] = src.ext_pin_five_irq;
  end

  // Software clears: a zero written clears, a one is ignored
  always_comb begin
    wr_clr = 16'h0000;
    if (sfr.wr && sfr.addr == `ADDR_LATCH_LOW) begin
      wr_clr[7:0] = ~sfr.wdata;
    end
    if (sfr.wr && sfr.addr == `ADDR_LATCH_HIGH) begin
      wr_clr[15:8] = ~sfr.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration
  always_comb begin
    eligible = 16'h0000;
    for (int i = `IL_FIRST_MASK; i <= `IL_LAST; i++) begin
      eligible[i] = latch_q[i] & source_enable_flag_q[i] & master_enable_flag_q;
    end
    eligible[`IL_PIN0] = eligible[`IL_PIN0] & ext_pin0_enable;
    soft_req = src.software_irq | src.undefined_opcode_irq;
    win_valid = 1'b1;
    win_clr = 16'h0000;
    win_vec = `VEC_RESET;
    // Non-maskable first, trap ranked above watchdog
    if (latch_q[`IL_TRAP]) begin
      win_vec = `VEC_TRAP;
      win_clr[`IL_TRAP] = 1'b1;
    end else if (latch_q[`IL_WDOG]) begin
      win_vec = `VEC_WDOG;
      win_clr[`IL_WDOG] = 1'b1;
    end else if (|eligible) begin
      for (int i = `IL_LAST; i >= `IL_FIRST_MASK; i--) begin
        if (eligible[i]) begin
          win_vec = 16'(`VEC_IL4 - `VEC_STEP * 16'(i - `IL_FIRST_MASK));
          win_clr = 16'h0000;
          win_clr[i] = 1'b1;
        end
      end
    end else begin
      win_valid = 1'b0;
    end
    irq_request_d = win_valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance sequence
  intc_pkg::ctl_state_t state_q, state_d;
  logic [7:0] mc_div_q, mc_div_d;
  logic [7:0] mc_cnt_q, mc_cnt_d;
  logic mc_en;
  logic accepting_d, accept_done_d;
  logic [15:0] accepted_vector_d;

  always_comb begin
    mc_en = (mc_div_q == 8'(MCYCLE_CLOCKS - 1));
    mc_div_d = mc_en ? 8'h00 : 8'(mc_div_q + 8'h01);
    state_d = state_q;
    mc_cnt_d = mc_cnt_q;
    accept = 1'b0;
    accepting_d = accepting_q;
    accept_done_d = 1'b0;
    accepted_vector_d = accepted_vector_q;
    acc_clr = 16'h0000;
    unique case (state_q)
      intc_pkg::st_idle: begin
        if (instr_done && (soft_req || win_valid)) begin
          accept = 1'b1;
          state_d = intc_pkg::st_seq;
          mc_cnt_d = 8'h00;
          mc_div_d = 8'h00;
          accepting_d = 1'b1;
          if (soft_req) begin
            accepted_vector_d = `VEC_SOFT;
          end else begin
            accepted_vector_d = win_vec;
            acc_clr = win_clr;
          end
        end
      end
      intc_pkg::st_seq: begin
        if (mc_en) begin
          mc_cnt_d = 8'(mc_cnt_q + 8'h01);
          if (mc_cnt_q == 8'(ACCEPT_MCYCLES - 1)) begin
            state_d = intc_pkg::st_idle;
            accepting_d = 1'b0;
            accept_done_d = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latches, enables and saved master enable
  always_comb begin
    latch_d = (latch_q & ~wr_clr & ~acc_clr) | set_vec;
    latch_d[1:0] = 2'b00;
    source_enable_flag_d = source_enable_flag_q;
    master_enable_flag_d = master_enable_flag_q;
    saved_enable_d = saved_enable_q;
    if (sfr.wr && sfr.addr == `ADDR_ENABLE_LOW) begin
      source_enable_flag_d[7:`IL_FIRST_MASK] = sfr.wdata[7:`IL_FIRST_MASK];
      master_enable_flag_d = sfr.wdata[`IMF_BIT];
    end
    if (sfr.wr && sfr.addr == `ADDR_ENABLE_HIGH) begin
      source_enable_flag_d[15:8] = sfr.wdata;
    end
    if (return_from_maskable && state_q == intc_pkg::st_idle) begin
      master_enable_flag_d = saved_enable_q[0];
      saved_enable_d = {1'b0, saved_enable_q[STACK_DEPTH-1:1]};
    end
    if (accept) begin
      saved_enable_d = {saved_enable_q[STACK_DEPTH-2:0], master_enable_flag_q};
      master_enable_flag_d = 1'b0;
    end
    malfunction_reset_d = (src.address_trap_irq & trap_output_select) |
                          (src.watchdog_irq & watchdog_output_select);
  end

  // Register reads
  always_comb begin
    rdata_d = 8'h00;
    if (sfr.rd) begin
      unique case (sfr.addr)
        `ADDR_ENABLE_LOW: rdata_d = {source_enable_flag_q[7:4], 3'b000, master_enable_flag_q};
        `ADDR_ENABLE_HIGH: rdata_d = source_enable_flag_q[15:8];
        `ADDR_LATCH_LOW: rdata_d = {latch_q[7:2], 2'b00};
        `ADDR_LATCH_HIGH: rdata_d = latch_q[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_q <= `LATCH_RESET;
      source_enable_flag_q <= `ENABLE_RESET;
      master_enable_flag_q <= 1'b0;
      saved_enable_q <= '0;
      state_q <= intc_pkg::st_idle;
      mc_div_q <= 8'h00;
      mc_cnt_q <= 8'h00;
      accepting_q <= 1'b0;
      accept_done_q <= 1'b0;
      accepted_vector_q <= `VEC_RESET;
      vector_q <= `VEC_RESET;
      irq_request_q <= 1'b0;
      rdata_q <= 8'h00;
      malfunction_reset_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      source_enable_flag_q <= source_enable_flag_d;
      master_enable_flag_q <= master_enable_flag_d;
      saved_enable_q <= saved_enable_d;
      state_q <= state_d;
      mc_div_q <= mc_div_d;
      mc_cnt_q <= mc_cnt_d;
      accepting_q <= accepting_d;
      accept_done_q <= accept_done_d;
      accepted_vector_q <= accepted_vector_d;
      vector_q <= win_vec;
      irq_request_q <= irq_request_d;
      rdata_q <= rdata_d;
      malfunction_reset_q <= malfunction_reset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int SEQ_CLKS = ACCEPT_MCYCLES * MCYCLE_CLOCKS;
  logic [15:0] span_q;
  always_ff @(posedge mclk) begin
    if (reset || accept) begin
      span_q <= 16'h0000;
    end else if (accepting_q) begin
      span_q <= 16'(span_q + 16'h0001);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence accept_s;
    accept;
  endsequence

  sequence enable_dropped_s;
    !master_enable_flag_q && accepting_q;
  endsequence

  latch_set_a: assert property ((set_vec != 16'h0000) |=>
    ((latch_q & $past(set_vec)) == $past(set_vec))) else $error("request not latched");
  reset_clear_a: assert property (@(posedge mclk) disable iff (1'b0)
    reset |=> latch_q == 16'h0000) else $error("latch not cleared by reset");
  no_sw_set_a: assert property ((set_vec == 16'h0000) |=>
    ((latch_q & ~$past(latch_q)) == 16'h0000)) else $error("latch rose without request");
  write_clear_a: assert property ((sfr.wr && sfr.addr == `ADDR_LATCH_LOW &&
    set_vec[7:0] == 8'h00 && !accept) |=>
    latch_q[7:2] == ($past(latch_q[7:2]) & $past(sfr.wdata[7:2])))
    else $error("latch write clear wrong");
  accept_clear_a: assert property ((accept && !soft_req) |=>
    ((latch_q & $past(win_clr)) == ($past(set_vec) & $past(win_clr))))
    else $error("accepted latch not cleared");
  imf_save_a: assert property (accept_s |=> enable_dropped_s and
    (saved_enable_q[0] == $past(master_enable_flag_q)))
    else $error("master enable not saved");
  seq_len_a: assert property (accept_done_q |->
    span_q == 16'(SEQ_CLKS)) else $error("acceptance length wrong");
  mask_gate_a: assert property ((!master_enable_flag_q && latch_q[3:2] == 2'b00) |=>
    !irq_request_q) else $error("masked request raised");
  shared_sel_a: assert property ((level12_source_select && !src.ext_pin_three_irq &&
    !latch_q[`IL_SHARED]) |=> !latch_q[`IL_SHARED]) else $error("unselected source latched");
  soft_vec_a: assert property ((accept && soft_req) |=>
    accepted_vector_q == `VEC_SOFT) else $error("software vector wrong");
  mask_need_a: assert property ((win_valid && !latch_q[`IL_TRAP] &&
    !latch_q[`IL_WDOG]) |-> master_enable_flag_q) else $error("maskable won while masked");
  done_pulse_a: assert property (accept_done_q |=> !accept_done_q)
    else $error("acceptance done not a pulse");

endmodule

// ---- verif/cpu_partner.sv ----
`timescale 1ns/1ps
module cpu_partner (
  input wire logic mclk, // System clock
  input wire logic accepting_q, // Acceptance running
  input wire logic accept_done_q, // End of acceptance
  output logic instr_done, // Instruction boundary pulse
  output logic return_from_maskable // Return pulse
);
  initial begin
    instr_done = 1'b0;
    return_from_maskable = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Stall, end an instruction, then count accepting cycles up to done
  task automatic accept(input int gap, output int cyc);
    int guard;
    guard = 0;
    cyc = 0;
    repeat (gap) begin
      @(posedge mclk);
      #1;
    end
    instr_done = 1'b1;
    @(posedge mclk);
    #1 instr_done = 1'b0;
    while (accept_done_q !== 1'b1 && guard < 100) begin
      if (accepting_q === 1'b1) cyc++;
      guard++;
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic ret();
    return_from_maskable = 1'b1;
    @(posedge mclk);
    #1 return_from_maskable = 1'b0;
    @(posedge mclk);
    #1;
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`include "intc_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  intc_pkg::sfr_req_t sfr = '0;
  intc_pkg::src_req_t src = '0;
  logic level12_source_select = 1'b0;
  logic ext_pin0_enable = 1'b0;
  logic trap_output_select = 1'b1;
  logic watchdog_output_select = 1'b1;
  logic instr_done, return_from_maskable, irq_request_q, accepting_q, accept_done_q;
  logic master_enable_flag_q, malfunction_reset_q;
  logic [7:0] rdata_q;
  logic [15:0] vector_q, accepted_vector_q;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc;
  always #12.5 mclk = ~mclk;
  prioritized_interrupt_latch_controller prioritized_interrupt_latch_controller_inst (
    .mclk(mclk), .reset(reset), .sfr(sfr), .rdata_q(rdata_q), .src(src),
    .level12_source_select(level12_source_select), .ext_pin0_enable(ext_pin0_enable),
    .trap_output_select(trap_output_select), .watchdog_output_select(watchdog_output_select),
    .instr_done(instr_done), .return_from_maskable(return_from_maskable),
    .irq_request_q(irq_request_q), .vector_q(vector_q), .accepting_q(accepting_q),
    .accept_done_q(accept_done_q), .accepted_vector_q(accepted_vector_q),
    .master_enable_flag_q(master_enable_flag_q), .malfunction_reset_q(malfunction_reset_q));
  cpu_partner cpu_partner_inst (.mclk(mclk), .accepting_q(accepting_q),
    .accept_done_q(accept_done_q),
    .instr_done(instr_done), .return_from_maskable(return_from_maskable));
  ////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    step();
    sfr = '0;
    step();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    step();
    sfr = '0;
    `CHK(rdata_q, e)
    step();
  endtask
  // Sources set by the caller, released after one edge
  task automatic fire();
    step();
    src = '0;
    step();
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(vector_q, 16'hfffe)
    rd_chk(8'h3c, 8'h00);
    rd_chk(8'h3d, 8'h00);
    rd_chk(8'h50, 8'h00);
  endtask
  task automatic t_latch();
    src.timer_one_irq = 1'b1;
    src.ext_pin_five_irq = 1'b1;
    fire();
    rd_chk(8'h3c, 8'h80);
    rd_chk(8'h3d, 8'h80);
    wr(8'h3c, 8'hff);
    rd_chk(8'h3c, 8'h80);
    wr(8'h3c, 8'h0c);
    rd_chk(8'h3c, 8'h00);
    rd_chk(8'h3d, 8'h80);
    wr(8'h3d, 8'h00);
  endtask
  task automatic t_race();
    sfr = '{addr: 8'h3d, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
    src.converter_done_irq = 1'b1;
    step();
    sfr = '0;
    src = '0;
    step();
    rd_chk(8'h3d, 8'h10);
    wr(8'h3d, 8'h00);
  endtask
  task automatic t_shared();
    src.ext_pin_three_irq = 1'b1;
    fire();
    rd_chk(8'h3d, 8'h00);
    src.timer_four_irq = 1'b1;
    fire();
    rd_chk(8'h3d, 8'h08);
    wr(8'h3d, 8'h00);
    level12_source_select = 1'b1;
    src.timer_four_irq = 1'b1;
    fire();
    rd_chk(8'h3d, 8'h00);
    src.ext_pin_three_irq = 1'b1;
    fire();
    rd_chk(8'h3d, 8'h08);
    wr(8'h3d, 8'h00);
  endtask
  task automatic t_prio();
    wr(8'h3a, 8'h00);
    wr(8'h3b, 8'hff);
    wr(8'h3a, 8'hf0);
    wr(8'h3a, 8'hf1);
    src.ext_pin_zero_irq = 1'b1;
    src.ext_pin_one_irq = 1'b1;
    src.timer_one_irq = 1'b1;
    src.serial_transmit_irq = 1'b1;
    fire();
    `CHK(irq_request_q, 1'b1)
    `CHK(vector_q, 16'hfff4)
    ext_pin0_enable = 1'b1;
    step();
    step();
    `CHK(vector_q, 16'hfff6)
    cpu_partner_inst.accept(3, cyc);
    `CHK(cyc, `ACCEPT_MCYCLES * `MCYCLE_CLOCKS)
    `CHK(accept_done_q, 1'b1)
    `CHK(accepting_q, 1'b0)
    `CHK(accepted_vector_q, 16'hfff6)
    `CHK(master_enable_flag_q, 1'b0)
    `CHK(irq_request_q, 1'b0)
    rd_chk(8'h3c, 8'ha0);
    cpu_partner_inst.ret();
    `CHK(master_enable_flag_q, 1'b1)
    step();
    `CHK(vector_q, 16'hfff4)
    wr(8'h3a, 8'h00);
    wr(8'h3c, 8'h0c);
    wr(8'h3d, 8'h00);
  endtask
  task automatic t_trap();
    src.address_trap_irq = 1'b1;
    step();
    `CHK(malfunction_reset_q, 1'b1)
    src = '0;
    src.watchdog_irq = 1'b1;
    step();
    `CHK(malfunction_reset_q, 1'b1)
    src = '0;
    step();
    `CHK(malfunction_reset_q, 1'b0)
    rd_chk(8'h3c, 8'h00);
    trap_output_select = 1'b0;
    watchdog_output_select = 1'b0;
    src.address_trap_irq = 1'b1;
    src.watchdog_irq = 1'b1;
    fire();
    rd_chk(8'h3c, 8'h0c);
    `CHK(irq_request_q, 1'b1)
    `CHK(vector_q, 16'hfffa)
    cpu_partner_inst.accept(0, cyc);
    `CHK(accepted_vector_q, 16'hfffa)
    `CHK(vector_q, 16'hfff8)
    cpu_partner_inst.accept(1, cyc);
    `CHK(accepted_vector_q, 16'hfff8)
    rd_chk(8'h3c, 8'h00);
  endtask
  // Reset in mid-run with a latch pending and master enable set
  task automatic t_rst_mid();
    wr(8'h3a, 8'h01);
    src.timer_three_irq = 1'b1;
    fire();
    rd_chk(8'h3d, 8'h04);
    `CHK(vector_q, 16'hffea)
    reset = 1'b1;
    trap_output_select = 1'b1;
    watchdog_output_select = 1'b1;
    repeat (3) step();
    reset = 1'b0;
    step();
    `CHK(master_enable_flag_q, 1'b0)
    `CHK(irq_request_q, 1'b0)
    `CHK(vector_q, 16'hfffe)
    rd_chk(8'h3d, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    #1 reset = 1'b0;
    step();
    t_reset();
    t_latch();
    t_race();
    t_shared();
    t_prio();
    t_trap();
    t_rst_mid();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
endmodule
